// ### design/hsr_status_regs.sv
// status, mask, impedance, supply and resonance period registers of the haptic driver
//
// How it works
// - five-bit mask, reset 24, interrupt mode only
// - mask bits 0,1 block overcurrent, thermal
// - mask bits 2,3 block undervoltage, done
// - mask bits 7:5 reserved, writable, reset zero
// - impedance loaded when diagnostics complete
// - supply reading follows supply measurement
// - supply reading updates only during playback
// - 10-bit period split upper/lower, reset zero
// - upper read freezes both until lower read
// - playback end releases freeze
// - one count is 24.39 microseconds
// - period samples taken only while playback active
// - status flags sticky, clear on read
// - interrupt mode pin is open drain
// - optional mean of last four periods
`default_nettype none
`include "hsr_map.svh"
module hsr_status_regs #(
	parameter int PERIOD_STEP_NS = `HSR_PERIOD_STEP_NS,
	parameter int AVG_DEPTH      = 4
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 arst_n_in,
	// register port
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire hsr_pkg::hsr_byte_t   reg_addr_in,
	input  wire hsr_pkg::hsr_byte_t   reg_wdata_in,
	output hsr_pkg::hsr_byte_t        reg_rdata_out,
	// events from the engine
	input  wire logic                 overcurrent_evt_in,
	input  wire logic                 thermal_evt_in,
	input  wire logic                 undervoltage_evt_in,
	input  wire logic                 process_done_evt_in,
	input  wire logic                 playback_active_in,
	input  wire logic                 diag_done_in,
	input  wire hsr_pkg::hsr_byte_t   impedance_meas_in,
	input  wire hsr_pkg::hsr_byte_t   supply_meas_in,
	input  wire logic                 period_valid_in,
	input  wire hsr_pkg::hsr_period_t period_meas_in,
	// trigger_irq_pin, open drain
	input  wire logic                 trigger_irq_pin_in,
	output logic                      trigger_irq_pin_out,
	output logic                      trigger_irq_pin_oe_out,
	output logic                      trigger_pin_is_input_out
);
	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	initial begin
		if (PERIOD_STEP_NS < 1) begin
			$error("hsr_status_regs: PERIOD_STEP_NS must be positive");
		end
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	hsr_pkg::hsr_byte_t   mask_q;
	hsr_pkg::hsr_byte_t   cfg_q;
	hsr_pkg::hsr_byte_t   impedance_result_q;
	hsr_pkg::hsr_byte_t   supply_reading_q;
	hsr_pkg::hsr_period_t resonance_period_count_q;
	logic [5:0]           upper_rsvd_q;
	logic [3:0]           flags_q;
	logic [3:0]           flags_d;
	hsr_pkg::hsr_lock_e   lock_q;
	hsr_pkg::hsr_lock_e   lock_d;
	logic                 playback_q;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic hit(input hsr_pkg::hsr_byte_t a, input hsr_pkg::hsr_byte_t ref_a);
		return a == ref_a;
	endfunction : hit

	wire logic rd_status_w    = reg_rd_in && hit(reg_addr_in, `HSR_ADDR_STATUS);
	wire logic rd_upper_w     = reg_rd_in && hit(reg_addr_in, `HSR_ADDR_PER_UPPER);
	wire logic rd_lower_w     = reg_rd_in && hit(reg_addr_in, `HSR_ADDR_PER_LOWER);
	wire logic wr_mask_w      = reg_wr_in && hit(reg_addr_in, `HSR_ADDR_IRQ_MASK);
	wire logic wr_cfg_w       = reg_wr_in && hit(reg_addr_in, `HSR_ADDR_MODE_CFG);
	wire logic wr_upper_w     = reg_wr_in && hit(reg_addr_in, `HSR_ADDR_PER_UPPER);
	wire logic playback_end_w = playback_q && !playback_active_in;

	wire logic [1:0] pin_func_w = cfg_q[`HSR_CFG_PIN_HI:`HSR_CFG_PIN_LO];
	wire logic irq_mode_w = pin_func_w == `HSR_PIN_FUNC_IRQ;
	wire logic [3:0] irq_src_w = flags_q & ~mask_q[3:0];
	wire logic pin_low_w = irq_mode_w && (|irq_src_w);

	// ---------------------------------------------------------------
	// period averaging
	// ---------------------------------------------------------------
	logic                 avg_valid_w;
	hsr_pkg::hsr_period_t avg_period_w;

	hsr_period_avg #(
		.DEPTH(AVG_DEPTH)
	) u_avg (
		.ref_clk_in      (ref_clk_in),
		.arst_n_in       (arst_n_in),
		.sample_valid_in (period_valid_in && playback_active_in),
		.sample_in       (period_meas_in),
		.averaging_off_in(cfg_q[`HSR_CFG_AVG_OFF]),
		.result_valid_out(avg_valid_w),
		.result_out      (avg_period_w)
	);

	// ---------------------------------------------------------------
	// next state of flags and freeze
	// ---------------------------------------------------------------
	// sticky, clear on read; a same-cycle event wins
	wire logic [3:0] evt_w = {process_done_evt_in, undervoltage_evt_in,
				  thermal_evt_in, overcurrent_evt_in};
	assign flags_d = (rd_status_w ? 4'h0 : flags_q) | evt_w;

	// freeze on upper read, release on lower read or playback end
	always_comb begin
		lock_d = lock_q;
		unique case (lock_q)
			hsr_pkg::HSR_LIVE:   if (rd_upper_w && !rd_lower_w) lock_d = hsr_pkg::HSR_FROZEN;
			hsr_pkg::HSR_FROZEN: if (rd_lower_w || playback_end_w) lock_d = hsr_pkg::HSR_LIVE;
		endcase
	end

	// ---------------------------------------------------------------
	// read data mux
	// ---------------------------------------------------------------
	hsr_pkg::hsr_byte_t rdata_w;
	always_comb begin
		unique case (reg_addr_in)
			`HSR_ADDR_STATUS:    rdata_w = {4'h0, flags_q};
			`HSR_ADDR_IRQ_MASK:  rdata_w = mask_q;
			`HSR_ADDR_IMPEDANCE: rdata_w = impedance_result_q;
			`HSR_ADDR_SUPPLY:    rdata_w = supply_reading_q;
			// upper bits 9:8, reserved 7:2 writable
			`HSR_ADDR_PER_UPPER: rdata_w = {upper_rsvd_q, resonance_period_count_q[9:8]};
			`HSR_ADDR_PER_LOWER: rdata_w = resonance_period_count_q[7:0];
			`HSR_ADDR_MODE_CFG:  rdata_w = cfg_q;
			default:             rdata_w = `HSR_ZERO8;
		endcase
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	// mask is fully writable, resets to 24
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mask_q       <= `HSR_MASK_RESET;
			cfg_q        <= `HSR_MODE_CFG_RESET;
			upper_rsvd_q <= '0;
		end else begin
			if (wr_mask_w) mask_q <= reg_wdata_in;
			if (wr_cfg_w)  cfg_q  <= reg_wdata_in;
			// reserved upper bits are plain storage; the period bits stay read-only
			if (wr_upper_w) upper_rsvd_q <= reg_wdata_in[`HSR_UPPER_RSVD_HI:`HSR_UPPER_RSVD_LO];
		end
	end

	// flags, freeze state and read data
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flags_q       <= 4'h0;
			lock_q        <= hsr_pkg::HSR_LIVE;
			playback_q    <= 1'b0;
			reg_rdata_out <= `HSR_ZERO8;
		end else begin
			flags_q       <= flags_d;
			lock_q        <= lock_d;
			playback_q    <= playback_active_in;
			reg_rdata_out <= reg_rd_in ? rdata_w : reg_rdata_out;
		end
	end

	// ---------------------------------------------------------------
	// measurement registers
	// ---------------------------------------------------------------
	// whole-word captures keep a bus read from seeing a torn value
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			impedance_result_q       <= `HSR_ZERO8;
			supply_reading_q         <= `HSR_ZERO8;
			resonance_period_count_q <= '0;
		end else begin
			if (diag_done_in) impedance_result_q <= impedance_meas_in;
			if (playback_active_in) supply_reading_q <= supply_meas_in;
			if (avg_valid_w && lock_q == hsr_pkg::HSR_LIVE && !rd_upper_w) begin
				resonance_period_count_q <= avg_period_w;
			end
		end
	end

	// ---------------------------------------------------------------
	// trigger pin, open drain
	// ---------------------------------------------------------------
	// output level is always low; only the enable moves, so the pin never drives high
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			trigger_irq_pin_out      <= 1'b0;
			trigger_irq_pin_oe_out   <= 1'b0;
			trigger_pin_is_input_out <= 1'b1;
		end else begin
			trigger_irq_pin_out      <= 1'b0;
			// drive low while in interrupt mode with an unmasked flag set
			trigger_irq_pin_oe_out   <= pin_low_w;
			trigger_pin_is_input_out <= !irq_mode_w;
		end
	end

	// pin input is consumed by the playback engine outside this bank
	wire logic unused_w = trigger_irq_pin_in;
endmodule : hsr_status_regs
`default_nettype wire

// ### design/hsr_map.svh
// register offsets, field positions and reset values of the haptic status readback bank
`ifndef HSR_MAP_SVH
`define HSR_MAP_SVH

`define HSR_ADDR_STATUS     8'h01
`define HSR_ADDR_IRQ_MASK   8'h02
`define HSR_ADDR_IMPEDANCE  8'h03
`define HSR_ADDR_SUPPLY     8'h04
`define HSR_ADDR_PER_UPPER  8'h05
`define HSR_ADDR_PER_LOWER  8'h06
`define HSR_ADDR_MODE_CFG   8'h07

`define HSR_MASK_RESET      8'h18
`define HSR_MODE_CFG_RESET  8'h54
`define HSR_ZERO8           8'h00

`define HSR_FLAG_OC         0
`define HSR_FLAG_THERM      1
`define HSR_FLAG_UV         2
`define HSR_FLAG_DONE       3
`define HSR_STATUS_DONE_BIT 3

`define HSR_CFG_AVG_OFF     6
`define HSR_CFG_PIN_LO      2
`define HSR_CFG_PIN_HI      3

`define HSR_UPPER_RSVD_HI   7
`define HSR_UPPER_RSVD_LO   2

`define HSR_PIN_FUNC_IRQ    2'h2
`define HSR_PERIOD_STEP_NS  24390

`endif

// ### design/hsr_pkg.sv
// types shared by the haptic status readback bank
`default_nettype none
package hsr_pkg;
	typedef logic [7:0] hsr_byte_t;
	typedef logic [9:0] hsr_period_t;
	typedef enum logic [1:0] {
		HSR_PIN_PULSE,
		HSR_PIN_LEVEL,
		HSR_PIN_IRQ,
		HSR_PIN_RSVD
	} hsr_pin_func_e;
	typedef enum {
		HSR_LIVE,
		HSR_FROZEN
	} hsr_lock_e;
endpackage : hsr_pkg
`default_nettype wire

// ### design/hsr_period_avg.sv
// running mean of the last four measured resonance periods
`default_nettype none
`include "hsr_map.svh"
module hsr_period_avg #(
	parameter int DEPTH = 4
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 arst_n_in,
	input  wire logic                 sample_valid_in,
	input  wire hsr_pkg::hsr_period_t sample_in,
	input  wire logic                 averaging_off_in,
	output logic                      result_valid_out,
	output hsr_pkg::hsr_period_t      result_out
);
	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	// the mean is a plain shift, so only a power of two depth works
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("hsr_period_avg: DEPTH must be a power of two");
		end
	end

	localparam int SHIFT = $clog2(DEPTH);
	localparam int SUM_W = 10 + SHIFT;

	hsr_pkg::hsr_period_t hist_q [DEPTH];
	logic [SUM_W-1:0]     sum_w;

	// sum of the newest sample and the newest DEPTH-1 history entries
	always_comb begin
		sum_w = SUM_W'(sample_in);
		for (int i = 0; i < DEPTH - 1; i++) begin
			sum_w = sum_w + SUM_W'(hist_q[i]);
		end
	end

	// ---------------------------------------------------------------
	// history shift register, preloaded with zero
	// ---------------------------------------------------------------
	// mean of four
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < DEPTH; i++) hist_q[i] <= '0;
			result_out       <= '0;
			result_valid_out <= 1'b0;
		end else begin
			result_valid_out <= sample_valid_in;
			if (sample_valid_in) begin
				hist_q[0] <= sample_in;
				for (int i = 1; i < DEPTH; i++) hist_q[i] <= hist_q[i-1];
				result_out <= averaging_off_in ? sample_in : sum_w[SUM_W-1:SHIFT];
			end
		end
	end
endmodule : hsr_period_avg
`default_nettype wire

// ### testbench/hsr_status_regs_chk.sv
// port assertions of the haptic status readback bank
`default_nettype none
module hsr_status_regs_chk (
	input wire logic               ref_clk_in,
	input wire logic               arst_n_in,
	input wire logic               reg_rd_in,
	input wire logic               reg_wr_in,
	input wire hsr_pkg::hsr_byte_t reg_wdata_in,
	input wire hsr_pkg::hsr_byte_t reg_addr_in,
	input wire hsr_pkg::hsr_byte_t reg_rdata_out,
	input wire logic               playback_active_in,
	input wire logic               diag_done_in,
	input wire hsr_pkg::hsr_byte_t impedance_meas_in,
	input wire hsr_pkg::hsr_byte_t supply_meas_in,
	input wire logic               overcurrent_evt_in,
	input wire logic               thermal_evt_in,
	input wire logic               undervoltage_evt_in,
	input wire logic               process_done_evt_in,
	input wire logic               trigger_irq_pin_out,
	input wire logic               trigger_irq_pin_oe_out,
	input wire logic               trigger_pin_is_input_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	// an event in the clearing cycle would legally re-set a flag
	wire logic any_evt = overcurrent_evt_in | thermal_evt_in | undervoltage_evt_in
		| process_done_evt_in;
	unmapped_read_a: assert property (reg_rd_in && (reg_addr_in == 8'h00 || reg_addr_in > 8'h07)
		|=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	upper_rsvd_a: assert property (reg_wr_in && reg_addr_in == 8'h05 ##1 !reg_wr_in
		##1 (reg_rd_in && reg_addr_in == 8'h05)
		|=> reg_rdata_out[7:2] == $past(reg_wdata_in[7:2], 3))
		else $error("period upper reserved bits lost");
	rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	drain_low_a: assert property (trigger_irq_pin_out == 1'b0)
		else $error("pin driven high");
	mode_gate_a: assert property ($past(trigger_pin_is_input_out) && trigger_pin_is_input_out
		|-> !trigger_irq_pin_oe_out) else $error("pin pulled outside interrupt mode");
	flag_clear_a: assert property (reg_rd_in && reg_addr_in == 8'h01 && !any_evt ##1 !any_evt
		|=> !trigger_irq_pin_oe_out) else $error("pin held after status read");
	imp_load_a: assert property (diag_done_in ##1 !diag_done_in ##1 (reg_rd_in && reg_addr_in == 8'h03)
		|=> reg_rdata_out == $past(impedance_meas_in, 3)) else $error("impedance not loaded");
	supply_live_a: assert property (playback_active_in ##1 (reg_rd_in && reg_addr_in == 8'h04)
		|=> reg_rdata_out == $past(supply_meas_in, 2)) else $error("supply reading stale");
	cover property (reg_rd_in && reg_addr_in == 8'h05);
	cover property ($rose(trigger_irq_pin_oe_out));
	cover property (playback_active_in && reg_rd_in && reg_addr_in == 8'h04);
endmodule : hsr_status_regs_chk
`default_nettype wire

// ### testbench/hsr_host_model.sv
// host model issuing register reads and writes to the bank
`default_nettype none
module hsr_host_model (
	input  wire logic               ref_clk_in,
	output logic                    reg_wr_out,
	output logic                    reg_rd_out,
	output hsr_pkg::hsr_byte_t      reg_addr_out,
	output hsr_pkg::hsr_byte_t      reg_wdata_out,
	input  wire hsr_pkg::hsr_byte_t reg_rdata_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_wr_out <= 1'b0;
		reg_rd_out <= 1'b0;
		reg_addr_out <= 8'h00;
		reg_wdata_out <= 8'h00;
	end
	// one write; data inverted afterwards so stale data never looks valid
	task automatic wr(input hsr_pkg::hsr_byte_t a, input hsr_pkg::hsr_byte_t d);
		@(posedge ref_clk_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge ref_clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask : wr
	// one read; data sampled 1 ns after the edge that registers it
	task automatic rd(input hsr_pkg::hsr_byte_t a, output hsr_pkg::hsr_byte_t d);
		@(posedge ref_clk_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= a;
		@(posedge ref_clk_in);
		reg_rd_out <= 1'b0;
		#1 d = reg_rdata_in;
	endtask : rd
endmodule : hsr_host_model
`default_nettype wire

// ### testbench/haptic_status_readback_regs_test.sv
// self-checking bench of the haptic status readback bank
`default_nettype none
module haptic_status_readback_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, arst_n = 1'b0, wr, rd, play = 1'b0, diag = 1'b0, pv = 1'b0, oe;
	logic pout, isin;
	logic [3:0] evt = 4'h0;
	hsr_pkg::hsr_byte_t addr, wdata, rdata, imp = 8'h00, sup = 8'h00;
	hsr_pkg::hsr_period_t pm = 10'h000;
	int error_cnt = 0, checked = 0;
	// open-drain pin with pull-up
	wire logic pin = oe ? pout : 1'b1;
	always #25 clk = ~clk;
	hsr_status_regs dut (.ref_clk_in(clk), .arst_n_in(arst_n), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.overcurrent_evt_in(evt[0]), .thermal_evt_in(evt[1]), .undervoltage_evt_in(evt[2]),
		.process_done_evt_in(evt[3]), .playback_active_in(play), .diag_done_in(diag),
		.impedance_meas_in(imp), .supply_meas_in(sup), .period_valid_in(pv),
		.period_meas_in(pm), .trigger_irq_pin_in(pin), .trigger_irq_pin_out(pout),
		.trigger_irq_pin_oe_out(oe), .trigger_pin_is_input_out(isin));
	hsr_host_model host (.ref_clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
	task automatic chk(input hsr_pkg::hsr_byte_t seen, input hsr_pkg::hsr_byte_t exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic rc(input hsr_pkg::hsr_byte_t a, input hsr_pkg::hsr_byte_t exp);
		hsr_pkg::hsr_byte_t d;
		host.rd(a, d);
		chk(d, exp);
	endtask : rc
	// event pulse, then long enough for flag and pin to follow
	task automatic pulse(input int i);
		@(posedge clk) evt <= 4'h1 << i;
		@(posedge clk) evt <= 4'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse
	task automatic per(input hsr_pkg::hsr_period_t p);
		@(posedge clk) pv <= 1'b1;
		pm <= p;
		@(posedge clk) pv <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : per
	task automatic t_regs();
		rc(8'h02, 8'h18);
		for (int a = 3; a < 7; a++) rc(8'(a), 8'h00);
		rc(8'h20, 8'h00);
		host.wr(8'h05, 8'hFF);
		rc(8'h05, 8'hFC);
		host.wr(8'h06, 8'hFF);
		rc(8'h06, 8'h00);
		host.wr(8'h05, 8'h00);
		rc(8'h05, 8'h00);
		host.wr(8'h02, 8'hFF);
		rc(8'h02, 8'hFF);
		host.wr(8'h03, 8'h55);
		rc(8'h03, 8'h00);
	endtask : t_regs
	// each flag raises, clears on read, and is kept off the pin by its mask bit
	task automatic t_irq();
		host.wr(8'h07, 8'h58);
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h02, 8'h00);
			pulse(i);
			chk({7'h00, oe}, 8'h01);
			chk({6'h00, isin, pout}, 8'h00);
			rc(8'h01, 8'h01 << i);
			repeat (2) @(posedge clk);
			#1 chk({7'h00, oe}, 8'h00);
			host.wr(8'h02, 8'h01 << i);
			pulse(i);
			chk({7'h00, oe}, 8'h00);
			rc(8'h01, 8'h01 << i);
		end
		host.wr(8'h07, 8'h54);
		pulse(0);
		chk({7'h00, oe}, 8'h00);
		chk({6'h00, isin, pout}, 8'h02);
		rc(8'h01, 8'h01);
	endtask : t_irq
	task automatic t_live();
		@(posedge clk) diag <= 1'b1;
		imp <= 8'hC3;
		@(posedge clk) diag <= 1'b0;
		rc(8'h03, 8'hC3);
		@(posedge clk) play <= 1'b1;
		sup <= 8'h5A;
		rc(8'h04, 8'h5A);
		@(posedge clk) play <= 1'b0;
		sup <= 8'h33;
		rc(8'h04, 8'h5A);
	endtask : t_live
	// freeze on upper read, release on lower read or end of playback
	task automatic t_period();
		host.wr(8'h07, 8'h58);
		@(posedge clk) play <= 1'b1;
		per(10'h2A5);
		rc(8'h05, 8'h02);
		per(10'h155);
		rc(8'h06, 8'hA5);
		per(10'h155);
		rc(8'h05, 8'h01);
		@(posedge clk) play <= 1'b0;
		@(posedge clk) play <= 1'b1;
		per(10'h3FF);
		rc(8'h05, 8'h03);
		rc(8'h06, 8'hFF);
		host.wr(8'h07, 8'h18);
		repeat (4) per(10'h100);
		per(10'h200);
		rc(8'h05, 8'h01);
		rc(8'h06, 8'h40);
	endtask : t_period
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_irq();
		t_live();
		t_period();
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule : haptic_status_readback_regs_test
bind hsr_status_regs hsr_status_regs_chk chk (.ref_clk_in, .arst_n_in, .reg_rd_in, .reg_addr_in,
	.reg_wr_in, .reg_wdata_in,
	.reg_rdata_out, .playback_active_in, .diag_done_in, .impedance_meas_in, .supply_meas_in,
	.overcurrent_evt_in, .thermal_evt_in, .undervoltage_evt_in, .process_done_evt_in,
	.trigger_irq_pin_out, .trigger_irq_pin_oe_out, .trigger_pin_is_input_out);
`default_nettype wire
